/* File: wch_pkg.sv */
// Package: register map, fields, resets and encodings of the window comparator
package wch_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] LOWER_OFF = 8'h04;
    localparam logic [7:0] UPPER_OFF = 8'h08;
    localparam logic [7:0] DELTA_OFF = 8'h0C;
    localparam logic [7:0] OPER_OFF = 8'h10;
    localparam logic [7:0] MDO_OFF = 8'h14;
    localparam logic [7:0] STAT_OFF = 8'h18;
    localparam int CTRL_ENSEL_LSB = 0;
    localparam int CTRL_MODE_BIT = 3;
    localparam int CTRL_OPSEL_LSB = 4;
    localparam int CTRL_TGT_BIT = 6;
    localparam int STAT_RES_BIT = 0;
    localparam int STAT_ACT_BIT = 1;
    localparam int STAT_OPND_LSB = 16;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [15:0] LOWER_RST = 16'h0000;
    localparam logic [15:0] UPPER_RST = 16'hFFFF;
    localparam logic [15:0] DELTA_RST = 16'h0000;
    localparam logic [15:0] OPER_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        EN_OFF = 3'b000,
        EN_ON = 3'b001,
        EN_PIN = 3'b010,
        EN_VIRT = 3'b011,
        EN_MASTER = 3'b100
    } wch_ensel_t;
    typedef enum logic [1:0] {
        OP_ANALOG = 2'b00,
        OP_VIRT = 2'b01,
        OP_NEST = 2'b10,
        OP_SOFT = 2'b11
    } wch_opsel_t;
    typedef enum logic {
        MODE_INSIDE = 1'b0,
        MODE_OUTSIDE = 1'b1
    } wch_mode_t;
    typedef enum logic {
        TGT_CHANNEL = 1'b0,
        TGT_NESTED = 1'b1
    } wch_tgt_t;
endpackage

/* File: wch_top.sv */
// Window comparator with hysteresis, enable gating and AXI4-Lite registers
`timescale 1ns/1ps
module wch_top (
    input wire logic clk_sys_in, // 100 MHz clock
    input wire logic rst_in, // Synchronous reset, high
    input wire logic clk_en_in, // Freezes all state when low
    input wire logic [wch_pkg::ADDR_W-1:0] s_axi_awaddr_in, // Write address
    input wire logic s_axi_awvalid_in, // Write address valid
    output logic s_axi_awready_out, // Write address ready
    input wire logic [31:0] s_axi_wdata_in, // Write data
    input wire logic [3:0] s_axi_wstrb_in, // Write byte strobes
    input wire logic s_axi_wvalid_in, // Write data valid
    output logic s_axi_wready_out, // Write data ready
    output logic [1:0] s_axi_bresp_out, // Write response
    output logic s_axi_bvalid_out, // Write response valid
    input wire logic s_axi_bready_in, // Write response ready
    input wire logic [wch_pkg::ADDR_W-1:0] s_axi_araddr_in, // Read address
    input wire logic s_axi_arvalid_in, // Read address valid
    output logic s_axi_arready_out, // Read address ready
    output logic [31:0] s_axi_rdata_out, // Read data
    output logic [1:0] s_axi_rresp_out, // Read response
    output logic s_axi_rvalid_out, // Read data valid
    input wire logic s_axi_rready_in, // Read data ready
    input wire logic island_en_in, // Enable from island digital input pin
    input wire logic virt_en_in, // Enable from virtual module output
    input wire logic [15:0] analog_word_in, // Analog channel word, pin domain
    input wire logic [15:0] virt_word_in, // Virtual module word output
    input wire logic [15:0] nest_word_in, // Word result of nested first stage
    output logic result_out, // Comparator result
    output logic chan_out, // Digital output channel bit
    output logic nest_res_out // Result toward the shared action target
);
    import wch_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Known register address
    function automatic logic reg_known(input logic [ADDR_W-1:0] a);
        return (a == CTRL_OFF) || (a == LOWER_OFF) || (a == UPPER_OFF) ||
               (a == DELTA_OFF) || (a == OPER_OFF) || (a == MDO_OFF) ||
               (a == STAT_OFF);
    endfunction

    // Merge write data into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus state

    logic [6:0] ctrl_q;
    logic [15:0] lower_q, upper_q, delta_q, oper_q;
    logic mdo_q;
    logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic do_wr;
    logic [31:0] rd_word;
    logic en_s1_q, en_s2_q;
    logic [15:0] ana_s1_q, ana_s2_q, opnd_q;
    logic result_q, chan_q, nest_q;
    logic active, result_d;
    logic signed [17:0] lo_m, lo_p, up_m, up_p, x;
    logic go1, go0;
    wch_ensel_t ensel;
    wch_opsel_t opsel;
    wch_mode_t mode;
    wch_tgt_t tgt;

    assign ensel = wch_ensel_t'(ctrl_q[CTRL_ENSEL_LSB +: 3]);
    assign opsel = wch_opsel_t'(ctrl_q[CTRL_OPSEL_LSB +: 2]);
    assign mode = wch_mode_t'(ctrl_q[CTRL_MODE_BIT]);
    assign tgt = wch_tgt_t'(ctrl_q[CTRL_TGT_BIT]);
    assign do_wr = aw_got_q && w_got_q && !bvalid_q;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels

    // Address and data taken in either order, response after both
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (clk_en_in) begin
            if (awready_q && s_axi_awvalid_in) begin
                aw_got_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr_in;
            end else if (!aw_got_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
            if (wready_q && s_axi_wvalid_in) begin
                w_got_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata_in;
                wstrb_q <= s_axi_wstrb_in;
            end else if (!w_got_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= reg_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready_in) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Register file; status is read only
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ctrl_q <= CTRL_RST;
            lower_q <= LOWER_RST;
            upper_q <= UPPER_RST;
            delta_q <= DELTA_RST;
            oper_q <= OPER_RST;
            mdo_q <= 1'b0;
        end else if (clk_en_in && do_wr) begin
            case (awaddr_q)
                CTRL_OFF: ctrl_q <= 7'(merge({25'h0, ctrl_q}, wdata_q, wstrb_q));
                LOWER_OFF: lower_q <= 16'(merge({16'h0, lower_q}, wdata_q, wstrb_q));
                UPPER_OFF: upper_q <= 16'(merge({16'h0, upper_q}, wdata_q, wstrb_q));
                DELTA_OFF: delta_q <= 16'(merge({16'h0, delta_q}, wdata_q, wstrb_q));
                OPER_OFF: oper_q <= 16'(merge({16'h0, oper_q}, wdata_q, wstrb_q));
                MDO_OFF: mdo_q <= 1'(merge({31'h0, mdo_q}, wdata_q, wstrb_q));
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channels

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr_in)
            CTRL_OFF: rd_word = {25'h0, ctrl_q};
            LOWER_OFF: rd_word = {16'h0, lower_q};
            UPPER_OFF: rd_word = {16'h0, upper_q};
            DELTA_OFF: rd_word = {16'h0, delta_q};
            OPER_OFF: rd_word = {16'h0, oper_q};
            MDO_OFF: rd_word = {31'h0, mdo_q};
            STAT_OFF: begin
                rd_word[STAT_RES_BIT] = result_q;
                rd_word[STAT_ACT_BIT] = active;
                rd_word[STAT_OPND_LSB +: 16] = opnd_q;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // One read under way at a time
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (clk_en_in) begin
            if (arready_q && s_axi_arvalid_in) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= reg_known(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready_in) begin
                rvalid_q <= 1'b0;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input sampling

    // Pin inputs pass two flip-flops
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            ana_s1_q <= 16'h0000;
            ana_s2_q <= 16'h0000;
        end else if (clk_en_in) begin
            en_s1_q <= island_en_in;
            en_s2_q <= en_s1_q;
            ana_s1_q <= analog_word_in;
            ana_s2_q <= ana_s1_q;
        end
    end

    // Operand sampled every cycle with clk_en_in high, enabled or not
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            opnd_q <= 16'h0000;
        end else if (clk_en_in) begin
            case (opsel)
                OP_ANALOG: opnd_q <= ana_s2_q;
                OP_VIRT: opnd_q <= virt_word_in;
                OP_NEST: opnd_q <= nest_word_in;
                OP_SOFT: opnd_q <= oper_q;
                default: opnd_q <= ana_s2_q;
            endcase
        end
    end

    // Enable source select
    always_comb begin
        case (ensel)
            EN_OFF: active = 1'b0;
            EN_ON: active = 1'b1;
            EN_PIN: active = en_s2_q;
            EN_VIRT: active = virt_en_in;
            EN_MASTER: active = mdo_q;
            default: active = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Window decision with hysteresis
    // Signed band edges, so an edge below zero can never be reached by the operand
    always_comb begin
        x = $signed({2'b00, opnd_q});
        lo_m = $signed({2'b00, lower_q}) - $signed({2'b00, delta_q});
        lo_p = $signed({2'b00, lower_q}) + $signed({2'b00, delta_q});
        up_m = $signed({2'b00, upper_q}) - $signed({2'b00, delta_q});
        up_p = $signed({2'b00, upper_q}) + $signed({2'b00, delta_q});
        if (mode == MODE_INSIDE) begin
            go1 = (x > lo_p) && (x < up_m);
            go0 = (x <= lo_m) || (x >= up_p);
        end else begin
            go1 = (x < lo_m) || (x > up_p);
            go0 = (x >= lo_p) && (x <= up_m);
        end
    end

    // Hold inside either band or while disabled
    always_comb begin
        result_d = result_q;
        if (active && go1) begin
            result_d = 1'b1;
        end else if (active && go0) begin
            result_d = 1'b0;
        end
    end

    // Result and its routing
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            result_q <= 1'b0;
            chan_q <= 1'b0;
            nest_q <= 1'b0;
        end else if (clk_en_in) begin
            result_q <= result_d;
            chan_q <= (tgt == TGT_CHANNEL) ? result_d : mdo_q;
            nest_q <= (tgt == TGT_NESTED) ? result_d : 1'b0;
        end
    end

    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign result_out = result_q;
    assign chan_out = chan_q;
    assign nest_res_out = nest_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    property p_off_frozen;
        clk_en_in && ensel == EN_OFF |=> $stable(result_q);
    endproperty
    a_off_frozen: assert property (p_off_frozen) else $error("off: result moved");
    property p_hold_off;
        !clk_en_in || !active |=> result_q == $past(result_q);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("disabled: result moved");
    property p_sample;
        clk_en_in && opsel == OP_NEST |=> opnd_q == $past(nest_word_in);
    endproperty
    a_sample: assert property (p_sample) else $error("operand not sampled");
    property p_zero_delta;
        clk_en_in && active && mode == MODE_INSIDE && delta_q == 16'h0000 &&
        opnd_q > lower_q && opnd_q < upper_q |=> result_q;
    endproperty
    a_zero_delta: assert property (p_zero_delta) else $error("inside: not 1");
    property p_in_high;
        clk_en_in && active && mode == MODE_INSIDE && x >= up_p |=> !result_q;
    endproperty
    a_in_high: assert property (p_in_high) else $error("inside: not 0 high");
    property p_in_low;
        clk_en_in && active && mode == MODE_INSIDE && x <= lo_m |=> !result_q;
    endproperty
    a_in_low: assert property (p_in_low) else $error("inside: not 0 low");
    property p_band;
        clk_en_in && !go1 && !go0 |=> $stable(result_q);
    endproperty
    a_band: assert property (p_band) else $error("band: result moved");
    property p_out_mode;
        clk_en_in && active && mode == MODE_OUTSIDE && (x < lo_m || x > up_p)
        |=> result_q;
    endproperty
    a_out_mode: assert property (p_out_mode) else $error("outside: not 1");
    property p_chan;
        clk_en_in && tgt == TGT_CHANNEL ##1 tgt == TGT_CHANNEL
        |-> chan_out == result_out;
    endproperty
    a_chan: assert property (p_chan) else $error("channel not result");
    property p_nest;
        clk_en_in && tgt == TGT_NESTED |=> chan_out == $past(mdo_q) &&
        nest_res_out == result_out;
    endproperty
    a_nest: assert property (p_nest) else $error("nested routing wrong");
    // Reset itself is the antecedent, so this one must not be disabled by it
    property p_reset;
        disable iff (1'b0) rst_in |=> !result_out && !chan_out && !nest_res_out;
    endproperty
    a_reset: assert property (p_reset) else $error("reset: result set");
    c_rise: cover property (clk_en_in && active ##1 $rose(result_q));
    c_fall: cover property (clk_en_in && active ##1 $fell(result_q));
    c_outside: cover property (mode == MODE_OUTSIDE && result_q);
    c_write: cover property (do_wr ##1 bvalid_q);
endmodule

/* File: wch_island_model.sv */
// Island-side sources feeding the comparator: enables and operand words
`timescale 1ns/1ps
module wch_island_model (
    input wire logic clk_sys_in, // 100 MHz clock
    input wire logic rst_in, // Synchronous reset, high
    input wire logic [15:0] analog_req_in, // Next analog channel word
    input wire logic [15:0] virt_req_in, // Next virtual module word
    input wire logic [15:0] nest_req_in, // Next first-stage word
    input wire logic island_en_req_in, // Next island input level
    input wire logic virt_en_req_in, // Next virtual output level
    output logic [15:0] analog_word_out, // Analog channel word
    output logic [15:0] virt_word_out, // Virtual module word
    output logic [15:0] nest_word_out, // First-stage counter word
    output logic island_en_out, // Island digital input
    output logic virt_en_out // Virtual module digital output
);
    ////////////////////////////////////////////////////////////////////////////////
    // Words change only at clock edges and are unsigned counts, never signed
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            analog_word_out <= 16'h0000;
            virt_word_out <= 16'h0000;
            nest_word_out <= 16'h0000;
        end else begin
            analog_word_out <= analog_req_in;
            virt_word_out <= virt_req_in;
            nest_word_out <= nest_req_in;
        end
    end
    // Boolean enable sources
    always_ff @(posedge clk_sys_in) begin
        island_en_out <= island_en_req_in;
        virt_en_out <= virt_en_req_in;
    end
endmodule

/* File: window_compare_hysteresis_tb.sv */
// Self-checking bench for the window comparator
`timescale 1ns/1ps
module window_compare_hysteresis_tb;
    import wch_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdq, rdata;
    logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic awr, wr_rdy, bv, arr, rv, result, chan, nest, ien, ven;
    logic [1:0] bresp, rresp, rsp;
    logic [15:0] an_req = 16'h0000, vw_req = 16'h0000, nw_req = 16'h0000, an_w, vw_w, nw_w;
    logic ien_req = 1'b1, ven_req = 1'b1, tgtn = 1'b0, ce = 1'b1;
    logic [3:0] ws = 4'hF;
    int err_total = 0, samples_checked = 0, src = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial begin
        forever #5 clk = ~clk;
    end
    wch_island_model island (.clk_sys_in(clk), .rst_in(rst), .analog_req_in(an_req),
        .virt_req_in(vw_req), .nest_req_in(nw_req), .island_en_req_in(ien_req),
        .virt_en_req_in(ven_req), .analog_word_out(an_w), .virt_word_out(vw_w),
        .nest_word_out(nw_w), .island_en_out(ien), .virt_en_out(ven));
    wch_top uut (.clk_sys_in(clk), .rst_in(rst), .clk_en_in(ce), .s_axi_awaddr_in(awa),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rrdy), .island_en_in(ien), .virt_en_in(ven),
        .analog_word_in(an_w), .virt_word_in(vw_w), .nest_word_in(nw_w),
        .result_out(result), .chan_out(chan), .nest_res_out(nest));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic hang();
        err_total++;
        $display("unexpected handshake expected answer seen none");
        tally_and_finish();
    endtask
    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_rdy === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        if (n == 40) hang();
        rsp = bresp;
        brdy <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        ara <= a; arv <= 1'b1; rrdy <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1) break;
        end
        if (n == 40) hang();
        rdq = rdata;
        rsp = rresp;
        rrdy <= 1'b0;
    endtask
    // Operand through the selected source, then wait past the pin sync delay
    task automatic push(input logic [15:0] x);
        case (src)
            0: an_req <= x;
            1: vw_req <= x;
            2: nw_req <= x;
            default: wr(OPER_OFF, {16'h0000, x});
        endcase
        repeat (8) @(posedge clk);
    endtask
    task automatic cfg(input logic [2:0] ens, input logic md, input int s, input logic t);
        src = s;
        tgtn = t;
        wr(CTRL_OFF, 32'({t, 2'(s), md, ens}));
    endtask
    task automatic seq(input logic [15:0] xs[8], input logic [7:0] ex);
        for (int i = 0; i < 8; i++) begin
            push(xs[i]);
            chk("result", ex[i], result);
            chk("routed", ex[i], tgtn ? nest : chan);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk("result_rst", 32'h0, result);
        rd(CTRL_OFF); chk("ctrl_rst", 32'h0, rdq);
        rd(UPPER_OFF); chk("upper_rst", {16'h0000, UPPER_RST}, rdq);
        rd(8'h1C); chk("unmapped_rd", 32'h0, rdq); chk("unmapped_rresp", RESP_SLVERR, rsp);
        wr(8'h1C, 32'hFFFF_FFFF); chk("unmapped_bresp", RESP_SLVERR, rsp);
        wr(STAT_OFF, 32'hFFFF_FFFF); chk("status_bresp", RESP_OKAY, rsp);
        rd(STAT_OFF); chk("status_res", 32'h0, rdq[STAT_RES_BIT]);
    endtask
    task automatic t_inside_plain();
        wr(LOWER_OFF, 32'h0000_7530);
        wr(UPPER_OFF, 32'h1234_9C40);
        rd(UPPER_OFF); chk("upper_width", 32'h0000_9C40, rdq);
        cfg(EN_ON, MODE_INSIDE, 0, TGT_CHANNEL);
        seq('{16'h7D00, 16'h7530, 16'h7531, 16'h9C40, 16'h9C3F, 16'hA410, 16'h6D60,
            16'h7D00}, 8'h95);
    endtask
    task automatic t_inside_band();
        wr(DELTA_OFF, 32'h0000_07D0);
        cfg(EN_ON, MODE_INSIDE, 1, TGT_CHANNEL);
        seq('{16'h6D60, 16'h7D00, 16'h7D01, 16'hA410, 16'h9470, 16'h946F, 16'h6D61,
            16'h6D60}, 8'h64);
    endtask
    task automatic t_outside();
        cfg(EN_ON, MODE_OUTSIDE, 2, TGT_NESTED);
        seq('{16'h6D5F, 16'h7CFF, 16'h7D00, 16'hA410, 16'hA411, 16'h9471, 16'h9470,
            16'h6D60}, 8'h33);
        chk("chan_nested", 32'h0, chan);
    endtask
    task automatic t_enable();
        wr(MDO_OFF, 32'h1);
        for (int c = 0; c < 8; c++) begin
            cfg(3'(c), MODE_INSIDE, 3, TGT_CHANNEL);
            repeat (6) @(posedge clk);
            rd(STAT_OFF); chk("active", 32'(c >= 1 && c <= 4), rdq[STAT_ACT_BIT]);
        end
        cfg(EN_VIRT, MODE_INSIDE, 3, TGT_CHANNEL);
        push(16'h88B8); chk("virt_on", 32'h1, result);
        ven_req <= 1'b0;
        repeat (4) @(posedge clk);
        push(16'h6D60); chk("frozen", 32'h1, result);
        rd(STAT_OFF); chk("sampled", 32'h6D60, rdq[31:16]);
        ven_req <= 1'b1;
        repeat (3) @(posedge clk);
        chk("reenable", 32'h0, result);
        wr(MDO_OFF, 32'h0);
        cfg(EN_MASTER, MODE_INSIDE, 3, TGT_CHANNEL);
        push(16'h88B8); chk("master_off", 32'h0, chan);
        wr(MDO_OFF, 32'h1);
        repeat (3) @(posedge clk);
        chk("master_on", 32'h1, chan);
        rd(MDO_OFF); chk("master_bit", 32'h1, rdq);
        cfg(EN_PIN, MODE_INSIDE, 3, TGT_CHANNEL);
        ien_req <= 1'b0;
        repeat (6) @(posedge clk);
        push(16'h6D60); chk("pin_off", 32'h1, result);
        ien_req <= 1'b1;
        repeat (6) @(posedge clk);
        chk("pin_on", 32'h0, result);
    endtask
    // Clock enable freezes all state; a mid-run reset clears result and registers
    task automatic t_freeze_reset();
        cfg(EN_ON, MODE_INSIDE, 1, TGT_CHANNEL);
        push(16'h88B8); chk("ce_before", 32'h1, result);
        ce <= 1'b0;
        vw_req <= 16'h6D60;
        repeat (8) @(posedge clk);
        chk("ce_frozen", 32'h1, result);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk("ce_resumed", 32'h0, result);
        push(16'h88B8); chk("pre_reset", 32'h1, chan);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("rst_result", 32'h0, result);
        chk("rst_chan", 32'h0, chan);
        rd(CTRL_OFF); chk("rst_ctrl", 32'h0, rdq);
        ws <= 4'h1;
        wr(LOWER_OFF, 32'h0000_1234);
        ws <= 4'hF;
        rd(LOWER_OFF); chk("strobe_lower", 32'h0000_0034, rdq);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_inside_plain();
        t_inside_band();
        t_outside();
        t_enable();
        t_freeze_reset();
        tally_and_finish();
    end
endmodule
